// >>> logic/imc_master.sv
// i2c master sequencer: start, repeated start, ack, stop, arbitration
`timescale 1ns/1ps
module imc_master #(
   parameter int ADDR_W = 4
) (
   // clock and reset
   input  wire logic              sys_clk,
   input  wire logic              reset_n,
   // avalon-mm slave
   input  wire logic [ADDR_W-1:0] avs_address,
   input  wire logic              avs_read,
   input  wire logic              avs_write,
   input  wire logic [31:0]       avs_writedata,
   input  wire logic [3:0]        avs_byteenable,
   output logic      [31:0]       avs_readdata,
   output logic                   avs_waitrequest,
   // i2c lines, open drain: oe high pulls the line low
   input  wire logic              scl_in,
   output logic                   scl_oe,
   input  wire logic              sda_in,
   output logic                   sda_oe,
   // processor wake request
   output logic                   wake_req
);

   ////////////////////////////////////////////////////////////////////////
   // registers

   imc_pkg::imc_state_e state_r;
   logic [7:0]  ctrl_r;
   logic [6:0]  div_r;
   logic [5:0]  c2_r;
   logic [7:0]  buf_r;
   logic [7:0]  shift_r;
   logic [3:0]  bitcnt_r;
   logic        bf_r, start_r, stop_r, irqf_r, write_collision_flag_r, bcol_r, wake_r;
   logic [6:0]  brg_r;
   logic        brg_run_r;
   logic        scl_oe_r, sda_oe_r;
   logic        scl_d_r, sda_d_r;
   logic        rd_pend_r;
   logic [31:0] rdata_r;

   logic        en, ie, sleeping;
   logic        brg_tick, brg_load;
   logic        wr_hit, rd_hit;
   logic        busy;
   logic        bus_start, bus_stop;
   logic        collide, seq_done, byte_done, stop_fin;

   assign en       = ctrl_r[imc_pkg::CTRL_EN_BIT];
   assign ie       = ctrl_r[imc_pkg::CTRL_IE_BIT];
   assign sleeping = ctrl_r[imc_pkg::CTRL_SLEEP_BIT];
   assign busy     = (state_r != imc_pkg::IMC_IDLE);

   ////////////////////////////////////////////////////////////////////////
   // avalon slave: writes take one cycle, reads answer in the second

   assign wr_hit = avs_write;
   assign rd_hit = avs_read & ~rd_pend_r;
   assign avs_waitrequest = avs_read & ~rd_pend_r;
   assign avs_readdata    = rdata_r;

   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
         rd_pend_r <= 1'b0;
      else
         rd_pend_r <= rd_hit;
   end

   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
         rdata_r <= 32'h0000_0000;
      else if (rd_hit)
      begin
         unique case (avs_address)
            imc_pkg::ADDR_CTRL:
               rdata_r <= {17'h0_0000, div_r, ctrl_r};
            imc_pkg::ADDR_CTRL2:
               rdata_r <= {26'h000_0000, c2_r};
            imc_pkg::ADDR_STATUS:
               rdata_r <= {23'h00_0000, wake_r, bcol_r, write_collision_flag_r, irqf_r,
                           stop_r, start_r, 2'h0, bf_r};
            imc_pkg::ADDR_BUF:
               rdata_r <= {24'h00_0000, buf_r};
            default:
               rdata_r <= 32'h0000_0000;
         endcase
      end
   end

   // control register; clearing the enable aborts everything but the sticky status flags
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         ctrl_r <= 8'h00;
         div_r  <= imc_pkg::RST_DIV[6:0];
      end
      else if (wr_hit && avs_address == imc_pkg::ADDR_CTRL)
      begin
         if (avs_byteenable[0])
            ctrl_r <= avs_writedata[7:0];
         if (avs_byteenable[1])
            div_r <= avs_writedata[imc_pkg::DIV_LSB +: imc_pkg::DIV_W];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // bit rate counter: reload from divider, tick on reaching zero

   assign brg_tick = brg_run_r & (brg_r == 7'h00);

   always_ff @(posedge sys_clk)
   begin
      if (!reset_n || !en)
      begin
         brg_r     <= 7'h00;
         brg_run_r <= 1'b0;
      end
      else if (brg_load)
      begin
         brg_r     <= div_r;
         brg_run_r <= 1'b1;
      end
      else if (!busy)
         brg_run_r <= 1'b0;
      else if (brg_tick)
         brg_run_r <= 1'b0;
      else if (brg_run_r)
         brg_r <= brg_r - 7'h01;
   end

   ////////////////////////////////////////////////////////////////////////
   // bus condition monitor, also used while another master owns the bus

   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
      end
      else
      begin
         scl_d_r <= scl_in;
         sda_d_r <= sda_in;
      end
   end

   assign bus_start = scl_in & scl_d_r & sda_d_r & ~sda_in;
   assign bus_stop  = scl_in & scl_d_r & ~sda_d_r & sda_in;

   ////////////////////////////////////////////////////////////////////////
   // sequencer

   always_comb
   begin
      brg_load  = 1'b0;
      collide   = 1'b0;
      seq_done  = 1'b0;
      byte_done = 1'b0;
      stop_fin  = 1'b0;
      unique case (state_r)
         imc_pkg::IMC_IDLE:
            brg_load = 1'b0;
         imc_pkg::IMC_ST_CHK:
            if (!sda_in || !scl_in)
               collide = 1'b1;
            else
               brg_load = 1'b1;
         imc_pkg::IMC_ST_HOLD:
            if (!scl_in)
               collide = 1'b1;
            else if (!sda_in || brg_tick)
               brg_load = 1'b1;
         imc_pkg::IMC_ST_LOW:
            seq_done = brg_tick;
         imc_pkg::IMC_RS_REL:
            // first count runs with the clock still held low
            if (scl_oe_r)
               brg_load = ~brg_run_r & sda_in;
            else if (scl_in && !sda_in)
               collide = 1'b1;
            else if (scl_in)
               brg_load = 1'b1;
         imc_pkg::IMC_RS_HI:
            if (!scl_in && sda_in)
               collide = 1'b1;
            else if (!sda_in || brg_tick)
               brg_load = 1'b1;
         imc_pkg::IMC_RS_LOW:
            seq_done = brg_tick;
         imc_pkg::IMC_ACK_LOW:
            brg_load = ~brg_run_r;
         imc_pkg::IMC_ACK_REL:
            if (scl_in && c2_r[imc_pkg::C2_ACK_DATA_VALUE_BIT] && !sda_in)
               collide = 1'b1;
            else if (scl_in)
               brg_load = 1'b1;
         imc_pkg::IMC_ACK_HI:
            seq_done = brg_tick;
         imc_pkg::IMC_SP_SDA:
            brg_load = ~sda_in;
         imc_pkg::IMC_SP_CNT:
            brg_load = 1'b0;
         imc_pkg::IMC_SP_REL:
            if (!scl_in && scl_d_r)
               collide = 1'b1;
            // load once the clock reads high, reload at its tick
            else if (scl_in && (!brg_run_r || brg_tick))
               brg_load = 1'b1;
         imc_pkg::IMC_SP_HI:
            if (brg_tick && !sda_in)
               collide = 1'b1;
            else if (brg_tick)
               stop_fin = 1'b1;
         imc_pkg::IMC_TX_LOW:
            brg_load = ~brg_run_r;
         imc_pkg::IMC_TX_HI:
            if (scl_in && !sda_oe_r && !sda_in && bitcnt_r != 4'h0)
               collide = 1'b1;
            else if (!brg_run_r)
               brg_load = scl_in;
            else if (brg_tick && bitcnt_r == 4'h0)
               byte_done = 1'b1;
      endcase
   end

   always_ff @(posedge sys_clk)
   begin
      if (!reset_n || !en)
      begin
         state_r  <= imc_pkg::IMC_IDLE;
         scl_oe_r <= 1'b0;
         sda_oe_r <= 1'b0;
         bitcnt_r <= 4'h0;
         shift_r  <= imc_pkg::RST_BYTE;
      end
      else if (collide)
      begin
         state_r  <= imc_pkg::IMC_IDLE;
         scl_oe_r <= 1'b0;
         sda_oe_r <= 1'b0;
         bitcnt_r <= 4'h0;
      end
      else
      begin
         unique case (state_r)
            imc_pkg::IMC_IDLE:
               if (wr_hit && avs_address == imc_pkg::ADDR_BUF)
               begin
                  shift_r  <= avs_writedata[7:0];
                  bitcnt_r <= imc_pkg::BITS_PER_BYTE;
                  state_r  <= imc_pkg::IMC_TX_LOW;
                  scl_oe_r <= 1'b1;
               end
               else if (wr_hit && avs_address == imc_pkg::ADDR_CTRL2
                        && avs_byteenable[0])
               begin
                  if (avs_writedata[imc_pkg::C2_SEN_BIT])
                     state_r <= imc_pkg::IMC_ST_CHK;
                  else if (avs_writedata[imc_pkg::C2_RSEN_BIT])
                  begin
                     state_r  <= imc_pkg::IMC_RS_REL;
                     sda_oe_r <= 1'b0;
                     scl_oe_r <= 1'b1;
                  end
                  else if (avs_writedata[imc_pkg::C2_STOP_BIT])
                  begin
                     state_r  <= imc_pkg::IMC_SP_SDA;
                     scl_oe_r <= 1'b1;
                     sda_oe_r <= 1'b1;
                  end
                  else if (avs_writedata[imc_pkg::C2_ACK_BIT])
                  begin
                     state_r  <= imc_pkg::IMC_ACK_LOW;
                     scl_oe_r <= 1'b1;
                     sda_oe_r <= ~avs_writedata[imc_pkg::C2_ACK_DATA_VALUE_BIT];
                  end
               end
            imc_pkg::IMC_ST_CHK:
               state_r <= imc_pkg::IMC_ST_HOLD;
            imc_pkg::IMC_ST_HOLD:
               if (brg_load)
               begin
                  sda_oe_r <= 1'b1;
                  state_r  <= imc_pkg::IMC_ST_LOW;
               end
            imc_pkg::IMC_ST_LOW,
            imc_pkg::IMC_RS_LOW,
            imc_pkg::IMC_ACK_HI:
               if (seq_done)
               begin
                  scl_oe_r <= 1'b1;
                  state_r  <= imc_pkg::IMC_IDLE;
               end
            imc_pkg::IMC_RS_REL:
               if (scl_oe_r && brg_tick)
                  scl_oe_r <= 1'b0;
               else if (!scl_oe_r && brg_load)
                  state_r <= imc_pkg::IMC_RS_HI;
            imc_pkg::IMC_RS_HI:
               if (brg_load)
               begin
                  sda_oe_r <= 1'b1;
                  state_r  <= imc_pkg::IMC_RS_LOW;
               end
            imc_pkg::IMC_ACK_LOW:
               if (brg_tick)
               begin
                  scl_oe_r <= 1'b0;
                  state_r  <= imc_pkg::IMC_ACK_REL;
               end
            imc_pkg::IMC_ACK_REL:
               if (brg_load)
                  state_r <= imc_pkg::IMC_ACK_HI;
            imc_pkg::IMC_SP_SDA:
               if (brg_load)
                  state_r <= imc_pkg::IMC_SP_CNT;
            imc_pkg::IMC_SP_CNT:
               if (brg_tick)
               begin
                  scl_oe_r <= 1'b0;
                  state_r  <= imc_pkg::IMC_SP_REL;
               end
            imc_pkg::IMC_SP_REL:
               if (brg_tick)
               begin
                  sda_oe_r <= 1'b0;
                  state_r  <= imc_pkg::IMC_SP_HI;
               end
            imc_pkg::IMC_SP_HI:
               if (stop_fin)
                  state_r <= imc_pkg::IMC_IDLE;
            imc_pkg::IMC_TX_LOW:
               if (brg_tick)
               begin
                  scl_oe_r <= 1'b0;
                  state_r  <= imc_pkg::IMC_TX_HI;
               end
               else if (bitcnt_r != 4'h0)
                  sda_oe_r <= ~shift_r[7];
               else
                  sda_oe_r <= 1'b0;
            imc_pkg::IMC_TX_HI:
               if (brg_tick)
               begin
                  scl_oe_r <= 1'b1;
                  if (byte_done)
                     state_r <= imc_pkg::IMC_IDLE;
                  else
                  begin
                     shift_r  <= {shift_r[6:0], 1'b0};
                     bitcnt_r <= bitcnt_r - 4'h1;
                     state_r  <= imc_pkg::IMC_TX_LOW;
                  end
               end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // control-two: command bits self clear, frozen while busy

   always_ff @(posedge sys_clk)
   begin
      if (!reset_n || !en)
         c2_r <= 6'h00;
      else
      begin
         if (wr_hit && avs_address == imc_pkg::ADDR_CTRL2
             && avs_byteenable[0])
         begin
            c2_r[imc_pkg::C2_ACK_DATA_VALUE_BIT] <=
               avs_writedata[imc_pkg::C2_ACK_DATA_VALUE_BIT];
            if (!busy)
               c2_r[imc_pkg::C2_CMD_W-1:0] <=
                  avs_writedata[imc_pkg::C2_CMD_W-1:0];
         end
         if (collide || seq_done || stop_fin)
            c2_r[imc_pkg::C2_CMD_W-1:0] <= 5'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // status flags: hardware set beats a same-cycle software clear

   logic st_clr;
   logic [8:0] clr_mask;
   assign st_clr   = wr_hit && avs_address == imc_pkg::ADDR_STATUS;
   assign clr_mask = st_clr ? avs_writedata[8:0] : 9'h000;

   always_ff @(posedge sys_clk)
   begin
      if (!reset_n || !en)
      begin
         start_r <= 1'b0;
         stop_r  <= 1'b0;
      end
      else if (bus_start)
      begin
         start_r <= 1'b1;
         stop_r  <= 1'b0;
      end
      else if (bus_stop)
      begin
         stop_r  <= 1'b1;
         start_r <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!reset_n || !en)
      begin
         bf_r  <= 1'b0;
         buf_r <= imc_pkg::RST_BYTE;
      end
      else if (collide)
         bf_r <= 1'b0;
      else if (wr_hit && avs_address == imc_pkg::ADDR_BUF && !busy)
      begin
         buf_r <= avs_writedata[7:0];
         bf_r  <= 1'b1;
      end
      else if (byte_done)
         bf_r <= 1'b0;
   end

   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         write_collision_flag_r <= 1'b0;
         bcol_r <= 1'b0;
         irqf_r <= 1'b0;
         wake_r <= 1'b0;
      end
      else
      begin
         if (wr_hit && avs_address == imc_pkg::ADDR_BUF && busy)
            write_collision_flag_r <= 1'b1;
         else if (clr_mask[imc_pkg::ST_WRITE_COLLISION_FLAG_BIT])
            write_collision_flag_r <= 1'b0;
         if (collide)
            bcol_r <= 1'b1;
         else if (clr_mask[imc_pkg::ST_BCOL_BIT])
            bcol_r <= 1'b0;
         if (stop_fin || seq_done || byte_done || (bus_stop && !busy))
            irqf_r <= 1'b1;
         else if (clr_mask[imc_pkg::ST_IRQF_BIT])
            irqf_r <= 1'b0;
         if (sleeping && ie && byte_done)
            wake_r <= 1'b1;
         else if (clr_mask[imc_pkg::ST_WAKE_BIT] || !sleeping)
            wake_r <= 1'b0;
      end
   end

   assign scl_oe   = scl_oe_r;
   assign sda_oe   = sda_oe_r;
   assign wake_req = wake_r;

endmodule

// >>> logic/imc_pkg.sv
// package: register map, fields, reset values and state encoding
package imc_pkg;

   // register word offsets (byte addresses)
   localparam logic [3:0] ADDR_CTRL    = 4'h0;
   localparam logic [3:0] ADDR_CTRL2   = 4'h4;
   localparam logic [3:0] ADDR_STATUS  = 4'h8;
   localparam logic [3:0] ADDR_BUF     = 4'hC;

   // control register fields
   localparam int CTRL_EN_BIT   = 0;
   localparam int CTRL_IE_BIT   = 1;
   localparam int CTRL_SLEEP_BIT = 2;
   localparam int DIV_LSB       = 8;
   localparam int DIV_W         = 7;

   // port_control_two fields
   localparam int C2_SEN_BIT    = 0;
   localparam int C2_RSEN_BIT   = 1;
   localparam int C2_STOP_BIT   = 2;
   localparam int C2_ACK_BIT    = 4;
   localparam int C2_ACK_DATA_VALUE_BIT  = 5;
   localparam int C2_CMD_W      = 5;

   // status fields (write one to clear for sticky flags)
   localparam int ST_BF_BIT     = 0;
   localparam int ST_START_BIT  = 3;
   localparam int ST_STOP_BIT   = 4;
   localparam int ST_IRQF_BIT   = 5;
   localparam int ST_WRITE_COLLISION_FLAG_BIT   = 6;
   localparam int ST_BCOL_BIT   = 7;
   localparam int ST_WAKE_BIT   = 8;

   // reset values
   localparam logic [7:0]  RST_DIV   = 8'h00;
   localparam logic [7:0]  RST_BYTE  = 8'h00;
   localparam logic [3:0]  BITS_PER_BYTE = 4'h8;

   typedef enum logic [3:0] {
      IMC_IDLE,
      IMC_ST_CHK, IMC_ST_HOLD, IMC_ST_LOW,
      IMC_RS_REL, IMC_RS_HI, IMC_RS_LOW,
      IMC_ACK_LOW, IMC_ACK_REL, IMC_ACK_HI,
      IMC_SP_SDA, IMC_SP_CNT, IMC_SP_REL, IMC_SP_HI,
      IMC_TX_LOW, IMC_TX_HI
   } imc_state_e;

   typedef struct packed {
      logic scl_oe;
      logic sda_oe;
   } imc_pins_s;

endpackage

// >>> tb/imc_bus_model.sv
// open-drain bus with pull-ups and another party able to hold either line
`timescale 1ns/1ps
module imc_bus_model (
   // design side
   input  wire logic scl_oe,
   input  wire logic sda_oe,
   // other master or slave
   input  wire logic pull_scl,
   input  wire logic pull_sda,
   // resolved lines
   output wire logic scl_in,
   output wire logic sda_in
);
   // wired-and: a released line reads high through its pull-up
   assign scl_in = !(scl_oe || pull_scl);
   assign sda_in = !(sda_oe || pull_sda);
endmodule

// >>> tb/imc_master_checker.sv
// port-level assertions for the i2c master sequencer
`timescale 1ns/1ps
module imc_master_checker #(
   parameter int ADDR_W = 4
) (
   // clock and reset
   input  wire logic              sys_clk,
   input  wire logic              reset_n,
   // avalon-mm slave
   input  wire logic [ADDR_W-1:0] avs_address,
   input  wire logic              avs_read,
   input  wire logic              avs_write,
   input  wire logic [31:0]       avs_writedata,
   input  wire logic [3:0]        avs_byteenable,
   input  wire logic [31:0]       avs_readdata,
   input  wire logic              avs_waitrequest,
   // i2c lines and wake
   input  wire logic              scl_in,
   input  wire logic              scl_oe,
   input  wire logic              sda_in,
   input  wire logic              sda_oe,
   input  wire logic              wake_req
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   ////////////////////////////////////////////////////////////////////////
   logic [6:0]  div_r;
   logic [15:0] hi_cnt_r;
   wire         c2_wr = avs_write && avs_address == imc_pkg::ADDR_CTRL2;
   // shadow of the divider so high phases can be bounded from below
   always_ff @(posedge sys_clk)
      if (!reset_n)
         div_r <= '0;
      else if (avs_write && avs_address == imc_pkg::ADDR_CTRL
               && avs_byteenable[1])
         div_r <= avs_writedata[imc_pkg::DIV_LSB +: imc_pkg::DIV_W];
   // saturating count of cycles the clock line has read high
   always_ff @(posedge sys_clk)
      if (!reset_n || !scl_in)
         hi_cnt_r <= '0;
      else if (hi_cnt_r != 16'hFFFF)
         hi_cnt_r <= hi_cnt_r + 16'h0001;
   ////////////////////////////////////////////////////////////////////////
   sequence s_read_walk;
      avs_waitrequest ##1 !avs_waitrequest;
   endsequence
   property p_reset_quiet;
      $rose(reset_n) |-> !scl_oe && !sda_oe && !wake_req;
   endproperty
   property p_write_ready;
      avs_write |-> !avs_waitrequest;
   endproperty
   property p_read_wait;
      $rose(avs_read) |-> s_read_walk;
   endproperty
   property p_data_holds;
      !avs_read && !$past(avs_read) |-> $stable(avs_readdata);
   endproperty
   property p_ack_drive;
      c2_wr && avs_writedata[imc_pkg::C2_ACK_BIT]
         |=> scl_oe
             && sda_oe == !$past(avs_writedata[imc_pkg::C2_ACK_DATA_VALUE_BIT]);
   endproperty
   property p_scl_high_min;
      $rose(scl_oe) |-> hi_cnt_r >= 16'(div_r);
   endproperty
   property p_stop_drive;
      c2_wr && avs_writedata[imc_pkg::C2_STOP_BIT] && scl_oe
         |-> ##[1:3] sda_oe;
   endproperty
   property p_sda_release;
      $fell(sda_oe) && scl_in && !scl_oe |-> hi_cnt_r >= 16'(div_r);
   endproperty
   property p_start_abort;
      c2_wr && avs_writedata[imc_pkg::C2_SEN_BIT] && !scl_oe && !sda_oe
         && (!sda_in || !scl_in) |=> (!scl_oe && !sda_oe) [*6];
   endproperty
   ////////////////////////////////////////////////////////////////////////
   a_reset_quiet: assert property (p_reset_quiet)
      else $error("lines or wake active after reset");
   a_write_ready: assert property (p_write_ready)
      else $error("write stalled");
   a_read_wait: assert property (p_read_wait)
      else $error("read handshake off");
   a_data_holds: assert property (p_data_holds)
      else $error("read data moved without a read");
   a_ack_drive: assert property (p_ack_drive)
      else $error("ack bit not driven");
   a_scl_high_min: assert property (p_scl_high_min)
      else $error("clock high phase too short");
   a_stop_drive: assert property (p_stop_drive)
      else $error("stop did not drive data low");
   a_sda_release: assert property (p_sda_release)
      else $error("data released too early");
   a_start_abort: assert property (p_start_abort)
      else $error("start not aborted on low line");
endmodule
bind imc_master imc_master_checker #(.ADDR_W(ADDR_W)) chk_u (
   .sys_clk(sys_clk), .reset_n(reset_n), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .scl_in(scl_in), .scl_oe(scl_oe), .sda_in(sda_in), .sda_oe(sda_oe),
   .wake_req(wake_req));

// >>> tb/test_imc_master.sv
// self-checking bench for the i2c master sequencer
`timescale 1ns/1ps
module test_imc_master;
   localparam logic [3:0]  A_CT = imc_pkg::ADDR_CTRL;
   localparam logic [3:0]  A_C2 = imc_pkg::ADDR_CTRL2;
   localparam logic [3:0]  A_ST = imc_pkg::ADDR_STATUS;
   localparam logic [3:0]  A_BF = imc_pkg::ADDR_BUF;
   // divider 4, irq enable, port enable
   localparam logic [31:0] CT_ON = 32'h00000403;
   logic        sys_clk = 1'b0;
   logic        reset_n = 1'b0;
   logic [3:0]  avs_address = 4'h0;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h00000000;
   logic [3:0]  avs_byteenable = 4'hF;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        scl_in, scl_oe, sda_in, sda_oe, wake_req;
   logic        pull_scl = 1'b0;
   logic        pull_sda = 1'b0;
   int          errors = 0;
   int          checks = 0;
   always #2.5 sys_clk = ~sys_clk;
   imc_master #(.ADDR_W(4)) dut_u (
      .sys_clk(sys_clk), .reset_n(reset_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .scl_in(scl_in), .scl_oe(scl_oe), .sda_in(sda_in), .sda_oe(sda_oe),
      .wake_req(wake_req));
   imc_bus_model bus_u (
      .scl_oe(scl_oe), .sda_oe(sda_oe), .pull_scl(pull_scl),
      .pull_sda(pull_sda), .scl_in(scl_in), .sda_in(sda_in));
   ////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         errors++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= 1'b1;
      do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
      avs_write <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic bus_rd(input logic [3:0] a, output logic [31:0] d);
      avs_address <= a;
      avs_read <= 1'b1;
      do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
      d = avs_readdata;
      avs_read <= 1'b0;
      @(posedge sys_clk);
   endtask
   // poll control two until a self-clearing bit drops
   task automatic wait_clear(input int b);
      logic [31:0] d = 32'hFFFFFFFF;
      for (int i = 0; i < 400 && d[b] !== 1'b0; i++)
         bus_rd(A_C2, d);
      check({31'h0, d[b]}, 32'h0);
   endtask
   task automatic st_is(input logic [31:0] mask, input logic [31:0] exp);
      logic [31:0] d;
      bus_rd(A_ST, d);
      check(d & mask, exp);
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_idle;
      logic [31:0] d;
      st_is(32'hFFFFFFFF, 32'h0);
      bus_rd(4'h2, d);
      check(d, 32'h0);
   endtask
   task automatic t_ack(input logic ack_data_value);
      logic [31:0] d;
      bus_wr(A_C2, {26'h0, ack_data_value, 5'h10});
      if (!ack_data_value)
      begin
         bus_wr(A_BF, 32'h000000A5);
         bus_wr(A_C2, 32'h00000004);
         bus_rd(A_BF, d);
         check(d, 32'h0);
      end
      wait_clear(imc_pkg::C2_ACK_BIT);
      bus_rd(A_C2, d);
      check(d & 32'h1F, 32'h0);
      st_is(32'h40, 32'h40);
   endtask
   task automatic t_stop;
      bus_wr(A_ST, 32'h00000020);
      bus_wr(A_C2, 32'h00000004);
      wait_clear(imc_pkg::C2_STOP_BIT);
      st_is(32'h30, 32'h30);
      check({30'h0, scl_in, sda_in}, 32'h3);
   endtask
   // another master runs a start and a stop while the port idles
   task automatic t_other_stop;
      bus_wr(A_ST, 32'h00000020);
      st_is(32'h20, 32'h0);
      pull_sda <= 1'b1;
      repeat (6) @(posedge sys_clk);
      pull_scl <= 1'b1;
      repeat (6) @(posedge sys_clk);
      pull_scl <= 1'b0;
      repeat (6) @(posedge sys_clk);
      pull_sda <= 1'b0;
      repeat (6) @(posedge sys_clk);
      st_is(32'h30, 32'h30);
   endtask
   task automatic t_start_clash;
      logic [31:0] d;
      pull_sda <= 1'b1;
      bus_wr(A_C2, 32'h00000001);
      bus_rd(A_C2, d);
      check(d & 32'h1, 32'h0);
      st_is(32'h80, 32'h80);
      pull_sda <= 1'b0;
      repeat (8) @(posedge sys_clk);
      st_is(32'h90, 32'h90);
   endtask
   // own start, then a repeated start, on a free bus
   task automatic t_start_rs;
      bus_wr(A_C2, 32'h00000001);
      wait_clear(imc_pkg::C2_SEN_BIT);
      st_is(32'h18, 32'h08);
      check({30'h0, scl_in, sda_in}, 32'h0);
      bus_wr(A_ST, 32'h00000020);
      bus_wr(A_C2, 32'h00000002);
      wait_clear(imc_pkg::C2_RSEN_BIT);
      st_is(32'h28, 32'h28);
      check({30'h0, scl_in, sda_in}, 32'h0);
   endtask
   // transmit while asleep; the finished byte must raise the wake request
   task automatic t_tx;
      int n = 0;
      bus_wr(A_CT, CT_ON | 32'h00000004);
      bus_wr(A_BF, 32'h000000C3);
      while (n < 400 && wake_req !== 1'b1)
      begin
         @(posedge sys_clk);
         n++;
      end
      check({31'h0, wake_req}, 32'h1);
      st_is(32'h101, 32'h100);
      bus_wr(A_CT, CT_ON);
      @(posedge sys_clk);
      check({31'h0, wake_req}, 32'h0);
   endtask
   task automatic t_disable;
      bus_wr(A_CT, 32'h00000400);
      st_is(32'h18, 32'h0);
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic tally_and_finish;
      $display("checks=%0d errors=%0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial
   begin
      repeat (5) @(posedge sys_clk);
      reset_n <= 1'b1;
      t_idle();
      bus_wr(A_CT, CT_ON);
      t_ack(1'b0);
      t_ack(1'b1);
      bus_wr(A_ST, 32'h00000040);
      st_is(32'h40, 32'h0);
      t_stop();
      t_start_rs();
      t_stop();
      t_other_stop();
      t_start_clash();
      t_tx();
      t_disable();
      tally_and_finish();
   end
   // the whole run needs several hundred cycles; this is far beyond
   initial
   begin
      #200000;
      errors++;
      tally_and_finish();
   end
endmodule
